// >>> core/fifo_feat_pkg.sv
// Shared constants, register map and pin carrier types of the cascadable FIFO feature block.
package fifo_feat_pkg;
  localparam int DATA_W = 9;
  localparam int PARITY_BIT = 8;
  localparam int DEPTH_DEF = 512;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] ADDR_PROG = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // Program register: threshold in the low six bits, parity option in the top three.
  localparam int THR_LSB = 0;
  localparam int THR_W = 6;
  localparam int THR_SHIFT = 4;
  localparam int PAR_LSB = 6;
  localparam int PAR_W = 3;
  localparam logic [8:0] PROG_RESET = 9'h001;
  localparam logic [2:0] PAR_CHECK_EVEN = 3'h6;
  localparam logic [2:0] PAR_CHECK_ODD = 3'h7;

  // Control register fields.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_W = 2;
  localparam int CTRL_PROG_VIEW = 2;

  // Status register fields.
  localparam int ST_CNT_LSB = 0;
  localparam int ST_CNT_W = 16;
  localparam int ST_EMPTY_N = 16;
  localparam int ST_FULL_N = 17;
  localparam int ST_HALF_N = 18;
  localparam int ST_ALMOST_N = 19;
  localparam int ST_WR_TOK = 20;
  localparam int ST_RD_TOK = 21;

  typedef enum logic [1:0] {
    MODE_STANDALONE,
    MODE_WIDTH,
    MODE_DEPTH
  } mode_t;

  typedef struct packed {
    logic write_clock;
    logic write_enable_n;
    logic [DATA_W-1:0] data_in;
  } wr_pins_t;

  typedef struct packed {
    logic read_clock;
    logic read_enable_n;
  } rd_pins_t;

  typedef struct packed {
    logic retransmit_n;
    logic cascade_in_n;
    logic first_load_n;
  } ctl_pins_t;

  typedef struct packed {
    logic [DATA_W-1:0] data_out;
    logic data_oe;
    logic parity_error_n;
  } q_pins_t;

  typedef struct packed {
    logic empty_flag_n;
    logic full_flag_n;
    logic half_full_flag_n;
    logic almost_edge_flag_n;
    logic cascade_out_n;
  } flag_pins_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_out_t;
endpackage

// >>> core/fifo_feat.sv
// Clocked 9-bit FIFO with parity check, retransmit, cascade token ring and APB control.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none

module fifo_feat #(
  parameter int DEPTH = fifo_feat_pkg::DEPTH_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fifo_feat_pkg::wr_pins_t wr_pins,
  input wire fifo_feat_pkg::rd_pins_t rd_pins,
  input wire fifo_feat_pkg::ctl_pins_t ctl_pins,
  output fifo_feat_pkg::q_pins_t q_pins,
  output fifo_feat_pkg::flag_pins_t flag_pins
);
  import fifo_feat_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] HALF_C = CW'(DEPTH / 2);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  // The whole state, memory included, lives in one record so that the
  // next-state logic below is the only place where anything changes.
  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] cnt;
    logic wrapped;
    logic wclk_q;
    logic rclk_q;
    logic init_done;
    logic wr_tok;
    logic rd_tok;
    logic expect_w;
    logic handoff_pend;
    logic [DATA_W-1:0] prog;
    mode_t mode;
    logic prog_view;
    logic ae;
    logic af;
    q_pins_t q;
    flag_pins_t f;
    apb_out_t apb;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic depth_mode;
  logic wr_edge;
  logic rd_edge;
  logic wr_take;
  logic rd_take;
  logic rt_act;
  logic par_check;
  logic [DATA_W-1:0] wr_word;
  logic [CW-1:0] cnt_n;
  logic [CW-1:0] thr_words;
  logic apb_access;
  logic apb_commit;
  logic [31:0] rd_val;
  logic rd_hit;

  assign prdata = s_r.apb.prdata;
  assign pready = s_r.apb.pready;
  assign pslverr = s_r.apb.pslverr;
  assign q_pins = s_r.q;
  assign flag_pins = s_r.f;

  always_comb begin
    s_nxt = s_r;
    depth_mode = (s_r.mode == MODE_DEPTH);
    thr_words = CW'(s_r.prog[THR_LSB +: THR_W]) << THR_SHIFT;
    par_check = (s_r.prog[PAR_LSB +: PAR_W] == PAR_CHECK_EVEN) ||
                (s_r.prog[PAR_LSB +: PAR_W] == PAR_CHECK_ODD);
    wr_edge = wr_pins.write_clock & ~s_r.wclk_q & s_r.init_done;
    rd_edge = rd_pins.read_clock & ~s_r.rclk_q & s_r.init_done;
    s_nxt.wclk_q = wr_pins.write_clock;
    s_nxt.rclk_q = rd_pins.read_clock;
    rt_act = ~ctl_pins.retransmit_n & ~depth_mode & s_r.init_done;
    // Reads and writes are refused while retransmit is low outside depth mode; the controller
    // is expected to keep both enables off then anyway.
    wr_take = wr_edge & ~wr_pins.write_enable_n & s_r.f.full_flag_n &
              (~depth_mode | s_r.wr_tok) & ~rt_act;
    rd_take = rd_edge & ~rd_pins.read_enable_n & s_r.f.empty_flag_n &
              (~depth_mode | s_r.rd_tok) & ~rt_act;
    wr_word = wr_pins.data_in;
    if (par_check) begin
      // Even count of ones under odd checking, or odd under even, is an error.
      wr_word[PARITY_BIT] = ~(^wr_pins.data_in ^ s_r.prog[PAR_LSB]);
    end
    cnt_n = s_r.cnt + CW'(wr_take) - CW'(rd_take);
    s_nxt.f.cascade_out_n = 1'b1;

    // The first-load strap is caught on the first clock after reset release.
    if (!s_r.init_done) begin
      s_nxt.init_done = 1'b1;
      s_nxt.wr_tok = ~ctl_pins.first_load_n;
      s_nxt.rd_tok = ~ctl_pins.first_load_n;
      s_nxt.q.data_oe = ~ctl_pins.first_load_n | ~depth_mode;
    end

    if (wr_take) begin
      s_nxt.mem[s_r.wr_ptr] = wr_word;
      s_nxt.wr_ptr = s_r.wr_ptr + AW'(1);
      if (s_r.wr_ptr == LAST_C) begin
        s_nxt.wrapped = 1'b1;
        if (depth_mode) begin
          s_nxt.wr_tok = 1'b0;
          s_nxt.f.cascade_out_n = 1'b0;
        end
      end
    end

    if (rd_edge && s_r.handoff_pend) begin
      s_nxt.handoff_pend = 1'b0;
      s_nxt.q.data_oe = 1'b0;
    end
    if (rd_take) begin
      s_nxt.q.data_out = s_r.mem[s_r.rd_ptr];
      s_nxt.q.data_oe = 1'b1;
      s_nxt.q.parity_error_n = par_check ? s_r.mem[s_r.rd_ptr][PARITY_BIT] : 1'b1;
      s_nxt.rd_ptr = s_r.rd_ptr + AW'(1);
      if (depth_mode && s_r.rd_ptr == LAST_C) begin
        s_nxt.rd_tok = 1'b0;
        s_nxt.handoff_pend = 1'b1;
        s_nxt.f.cascade_out_n = 1'b0;
      end
    end
    s_nxt.cnt = cnt_n;

    // Write-clock side flags, refreshed on every edge whatever the enable.
    if (wr_edge) begin
      s_nxt.f.full_flag_n = ~(cnt_n == DEPTH_C);
      s_nxt.f.half_full_flag_n = ~(cnt_n > HALF_C);
      s_nxt.af = ~depth_mode & ((DEPTH_C - cnt_n) <= thr_words);
    end
    // Read-clock side flags.
    if (rd_edge) begin
      s_nxt.f.empty_flag_n = ~(cnt_n == '0);
      s_nxt.ae = ~depth_mode & (cnt_n <= thr_words);
    end

    if (rt_act) begin
      s_nxt.rd_ptr = '0;
      s_nxt.cnt = s_r.wrapped ? DEPTH_C : CW'(s_r.wr_ptr);
      s_nxt.f.full_flag_n = ~(s_nxt.cnt == DEPTH_C);
      s_nxt.f.half_full_flag_n = ~(s_nxt.cnt > HALF_C);
      s_nxt.f.empty_flag_n = ~(s_nxt.cnt == '0);
      s_nxt.af = (DEPTH_C - s_nxt.cnt) <= thr_words;
      s_nxt.ae = s_nxt.cnt <= thr_words;
    end
    s_nxt.f.almost_edge_flag_n = ~(s_nxt.ae | s_nxt.af);

    // Incoming token pulses alternate write then read on every device.
    if (!ctl_pins.cascade_in_n && depth_mode && s_r.init_done) begin
      s_nxt.expect_w = ~s_r.expect_w;
      if (s_r.expect_w) begin
        s_nxt.wr_tok = 1'b1;
      end else begin
        s_nxt.rd_tok = 1'b1;
      end
    end

    if (s_r.prog_view) begin
      s_nxt.q.data_out = s_r.prog;
      s_nxt.q.data_oe = ~depth_mode | ~ctl_pins.first_load_n;
    end

    // APB slave: pready rises one cycle into the access phase.
    apb_access = psel & penable;
    apb_commit = apb_access & s_r.apb.pready;
    s_nxt.apb.pready = apb_access & ~s_r.apb.pready;
    rd_val = '0;
    rd_hit = 1'b1;
    if (paddr == ADDR_PROG) begin
      rd_val[DATA_W-1:0] = s_r.prog;
    end else if (paddr == ADDR_CTRL) begin
      rd_val[CTRL_MODE_LSB +: CTRL_MODE_W] = s_r.mode;
      rd_val[CTRL_PROG_VIEW] = s_r.prog_view;
    end else if (paddr == ADDR_STATUS) begin
      rd_val[ST_CNT_LSB +: ST_CNT_W] = ST_CNT_W'(s_r.cnt);
      rd_val[ST_EMPTY_N] = s_r.f.empty_flag_n;
      rd_val[ST_FULL_N] = s_r.f.full_flag_n;
      rd_val[ST_HALF_N] = s_r.f.half_full_flag_n;
      rd_val[ST_ALMOST_N] = s_r.f.almost_edge_flag_n;
      rd_val[ST_WR_TOK] = s_r.wr_tok;
      rd_val[ST_RD_TOK] = s_r.rd_tok;
    end else begin
      rd_hit = 1'b0;
    end
    if (apb_access && !s_r.apb.pready) begin
      s_nxt.apb.prdata = pwrite ? 32'h0000_0000 : rd_val;
      s_nxt.apb.pslverr = ~rd_hit | (pwrite & (paddr == ADDR_STATUS));
    end else begin
      s_nxt.apb.prdata = 32'h0000_0000;
      s_nxt.apb.pslverr = 1'b0;
    end
    if (apb_commit && pwrite) begin
      if (paddr == ADDR_PROG) begin
        s_nxt.prog[PAR_LSB +: PAR_W] = pwdata[PAR_LSB +: PAR_W];
        if (!depth_mode) begin
          s_nxt.prog[THR_LSB +: THR_W] = pwdata[THR_LSB +: THR_W];
        end
      end else if (paddr == ADDR_CTRL) begin
        s_nxt.mode = mode_t'(pwdata[CTRL_MODE_LSB +: CTRL_MODE_W]);
        s_nxt.prog_view = pwdata[CTRL_PROG_VIEW];
        if (s_r.prog_view && !pwdata[CTRL_PROG_VIEW]) begin
          s_nxt.q.data_oe = (s_nxt.mode != MODE_DEPTH) | s_r.rd_tok;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.prog <= PROG_RESET;
      s_r.mode <= MODE_STANDALONE;
      s_r.expect_w <= 1'b1;
      s_r.ae <= 1'b1;
      s_r.q.parity_error_n <= 1'b1;
      s_r.f.empty_flag_n <= 1'b0;
      s_r.f.full_flag_n <= 1'b1;
      s_r.f.half_full_flag_n <= 1'b1;
      s_r.f.almost_edge_flag_n <= 1'b0;
      s_r.f.cascade_out_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  AST_PARITY_STORE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_take && par_check) |=>
      s_r.mem[$past(s_r.wr_ptr)][PARITY_BIT] ==
      ~(^$past(wr_pins.data_in) ^ $past(s_r.prog[PAR_LSB])))
    else $error("stored parity bit wrong");

  AST_RT_REWIND: assert property (@(posedge pclk) disable iff (!presetn)
    rt_act |=> (s_r.rd_ptr == '0) && (s_r.cnt == ($past(s_r.wrapped) ? DEPTH_C :
      CW'($past(s_r.wr_ptr)))))
    else $error("retransmit did not rewind");

  AST_RT_DEPTH_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
    (depth_mode && !ctl_pins.retransmit_n && !rd_take && !wr_take) |=>
      $stable(s_r.rd_ptr) && $stable(s_r.wr_ptr))
    else $error("retransmit acted in depth mode");

  AST_HANDOFF_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(s_r.f.cascade_out_n) |=> s_r.f.cascade_out_n)
    else $error("cascade pulse longer than one cycle");

  AST_FLOAT_AFTER_HANDOFF: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_edge && s_r.handoff_pend && !rd_take && !s_r.prog_view) |=> !s_r.q.data_oe)
    else $error("output not floated after handoff");

  AST_COUNT_BOUND: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.cnt <= DEPTH_C)
    else $error("count above depth");

  AST_DISABLED_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_edge && wr_pins.write_enable_n && !rd_take && !rt_act) |=>
      $stable(s_r.cnt) && (s_r.af == (!depth_mode && (DEPTH_C - s_r.cnt) <= thr_words)))
    else $error("disabled write edge moved count or missed flag");

  AST_READ_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_take && !wr_take && !rt_act) |=> (s_r.cnt == $past(s_r.cnt) - CW'(1)) &&
      (s_r.ae == (!depth_mode && s_r.cnt <= thr_words)))
    else $error("read did not update count and flag together");

  AST_PROG_VIEW_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
    (s_r.prog_view && depth_mode && ctl_pins.first_load_n) |=> !s_r.q.data_oe)
    else $error("non-first device drove program contents");

  AST_CASCADE_PROG: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_commit && pwrite && paddr == ADDR_PROG && depth_mode) |=>
      $stable(s_r.prog[THR_LSB +: THR_W]))
    else $error("threshold changed while cascaded");

  AST_PARITY_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_take && par_check) |=>
      s_r.q.parity_error_n == $past(s_r.mem[s_r.rd_ptr][PARITY_BIT]))
    else $error("parity error output does not follow stored bit");

  AST_PARITY_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_take && !par_check) |=> s_r.q.parity_error_n)
    else $error("parity error flagged with checking off");

  AST_RT_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
    rt_act |=> (s_r.f.empty_flag_n == (s_r.cnt != '0)) &&
      (s_r.f.full_flag_n == (s_r.cnt != DEPTH_C)))
    else $error("flags not refreshed by retransmit");

  AST_RT_KEEPS_WRITES: assert property (@(posedge pclk) disable iff (!presetn)
    rt_act |=> $stable(s_r.wr_ptr) && $stable(s_r.wrapped))
    else $error("retransmit moved the write side");

  AST_READ_UPDATE_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_edge && rd_pins.read_enable_n && !wr_take && !rt_act) |=>
      $stable(s_r.cnt) && $stable(s_r.rd_ptr) && (s_r.f.empty_flag_n == (s_r.cnt != '0)))
    else $error("disabled read edge moved data or missed flag");

  AST_EMPTY_READ_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_edge && !s_r.f.empty_flag_n && !rt_act) |=> $stable(s_r.rd_ptr))
    else $error("read taken while empty flag showed empty");

  AST_WRITE_REFRESH: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_edge && !rt_act) |=> (s_r.f.full_flag_n == (s_r.cnt != DEPTH_C)) &&
      (s_r.f.half_full_flag_n == !(s_r.cnt > HALF_C)))
    else $error("write edge did not refresh full or half flag");

  AST_READ_TOKEN: assert property (@(posedge pclk) disable iff (!presetn)
    (depth_mode && !s_r.rd_tok) |=> $stable(s_r.rd_ptr))
    else $error("read without the read token");

  AST_WRITE_TOKEN: assert property (@(posedge pclk) disable iff (!presetn)
    (depth_mode && !s_r.wr_tok) |=> $stable(s_r.wr_ptr))
    else $error("write without the write token");

  AST_STRAP_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s_r.init_done) |-> (s_r.wr_tok != $past(ctl_pins.first_load_n)) &&
      (s_r.rd_tok != $past(ctl_pins.first_load_n)))
    else $error("tokens do not follow the first-load strap");

  AST_TOKEN_ARRIVAL: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctl_pins.cascade_in_n && depth_mode && s_r.init_done) |=>
      (s_r.expect_w != $past(s_r.expect_w)) &&
      ($past(s_r.expect_w) ? s_r.wr_tok : s_r.rd_tok))
    else $error("arriving token not taken in turn");

  AST_READ_DRIVES: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_take && !s_r.prog_view) |=> s_r.q.data_oe)
    else $error("read word not driven onto the output");

endmodule
`default_nettype wire

// >>> dv/fifo_ctrl_model.sv
// Writing and reading controller model that drives the FIFO clock, enable and control pins.
`timescale 1ns/100ps
`default_nettype none
module fifo_ctrl_model (
  input wire logic pclk,
  input wire logic cascade_out_n,
  output fifo_feat_pkg::wr_pins_t wr_pins,
  output fifo_feat_pkg::rd_pins_t rd_pins,
  output fifo_feat_pkg::ctl_pins_t ctl_pins,
  output logic rd_done
);
  import fifo_feat_pkg::*;
  logic rt_n;
  // A ring of one device, which is also the first-load device.
  assign ctl_pins = '{rt_n, cascade_out_n, 1'b0};
  initial begin
    wr_pins = '{1'b0, 1'b1, 9'h000};
    rd_pins = '{1'b0, 1'b1};
    rt_n = 1'b1;
    rd_done = 1'b0;
  end
  // Data lines show the inverse of the last word once the write is over.
  task automatic wr(input logic en_n, input logic [8:0] d);
    @(posedge pclk);
    wr_pins <= '{1'b1, en_n, d};
    @(posedge pclk);
    wr_pins <= '{1'b0, 1'b1, ~d};
  endtask
  task automatic rd(input logic en_n);
    @(posedge pclk);
    rd_pins <= '{1'b1, en_n};
    @(posedge pclk);
    rd_pins <= '{1'b0, 1'b1};
    rd_done <= ~en_n;
    @(posedge pclk);
    rd_done <= 1'b0;
  endtask
  // Both clocks stay low during the pulse and the recovery time after it.
  task automatic rt();
    @(posedge pclk);
    rt_n <= 1'b0;
    @(posedge pclk);
    rt_n <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// >>> dv/test_fifo_feat.sv
// Self-checking bench for the FIFO feature block: parity, almost flag, retransmit.
`timescale 1ns/100ps
`default_nettype none
module test_fifo_feat;
  import fifo_feat_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_done, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [8:0] d, x;
  wr_pins_t wr_pins;
  rd_pins_t rd_pins;
  ctl_pins_t ctl_pins;
  q_pins_t q_pins;
  flag_pins_t flag_pins;
  int n_mismatch, check_count;
  logic [8:0] exp_q[$];
  logic [8:0] mem[$];
  fifo_feat #(.DEPTH(128)) fifo_feat_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wr_pins(wr_pins), .rd_pins(rd_pins),
    .ctl_pins(ctl_pins), .q_pins(q_pins), .flag_pins(flag_pins));
  fifo_ctrl_model fifo_ctrl_model_i (.pclk(pclk), .cascade_out_n(flag_pins.cascade_out_n),
    .wr_pins(wr_pins), .rd_pins(rd_pins), .ctl_pins(ctl_pins), .rd_done(rd_done));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] want);
    check_count++;
    if (got !== want) begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, want);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Odd check: a word with an odd count of ones is good and reads with the error flag high.
  function automatic logic [8:0] ex(input logic [8:0] w);
    return {^w, w[7:0]};
  endfunction
  task automatic rd_word(input int i);
    exp_q.push_back(ex(mem[i]));
    fifo_ctrl_model_i.rd(1'b0);
  endtask
  always @(posedge pclk) begin
    if (rd_done === 1'b1) begin
      x = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h000;
      chk({q_pins.parity_error_n, q_pins.data_out[7:0]}, x);
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    $display("mismatch at %0t: timeout", $time);
    results();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_mismatch = 0;
    check_count = 0;
    r = $urandom(3441);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r[19:0], {4'b0110, 16'h0000});
    chk({q_pins.data_oe, q_pins.parity_error_n, flag_pins}, {2'b11, 5'b01101});
    apb(1'b0, 8'h0C, 32'h0);
    chk({e, r}, {1'b1, 32'h0});
    apb(1'b1, ADDR_PROG, {23'h0, PAR_CHECK_ODD, 6'h02});
    apb(1'b0, ADDR_PROG, 32'h0);
    chk(r, {23'h0, PAR_CHECK_ODD, 6'h02});
    // No more writes than the depth before a retransmit.
    for (int i = 0; i < 34; i++) begin
      d = 9'($urandom);
      mem.push_back(d);
      fifo_ctrl_model_i.wr(1'b0, d);
    end
    fifo_ctrl_model_i.wr(1'b1, 9'($urandom));
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({r[19:17], r[15:0]}, {3'b011, 16'd34});
    fifo_ctrl_model_i.rd(1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({r[16], r[15:0]}, {1'b1, 16'd34});
    rd_word(0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({r[19], r[15:0]}, {1'b1, 16'd33});
    fifo_ctrl_model_i.rd(1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({r[19], r[15:0]}, {1'b1, 16'd33});
    rd_word(1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({r[19], r[15:0]}, {1'b0, 16'd32});
    fifo_ctrl_model_i.rt();
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({r[16], r[15:0]}, {1'b1, 16'd34});
    d = 9'($urandom);
    mem.push_back(d);
    fifo_ctrl_model_i.wr(1'b0, d);
    for (int i = 0; i < 35; i++) begin
      rd_word(i);
    end
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({r[16], r[15:0]}, {1'b0, 16'd0});
    chk(32'(exp_q.size()), 32'd0);
    // Cascade mode: retransmit is ignored and a program write keeps the threshold.
    apb(1'b1, ADDR_CTRL, 32'h0000_0002);
    fifo_ctrl_model_i.rt();
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({r[16], r[15:0]}, {1'b0, 16'd0});
    apb(1'b1, ADDR_PROG, {23'h0, PAR_CHECK_EVEN, 6'h05});
    apb(1'b1, ADDR_CTRL, 32'h0000_0006);
    repeat (2) @(posedge pclk);
    chk({q_pins.data_oe, q_pins.data_out}, {1'b1, PAR_CHECK_EVEN, 6'h02});
    results();
  end
endmodule
`default_nettype wire
